/* File: ccp_pkg.sv */
// package: register map, mode codes and shared types of the capture/compare/pwm unit
package ccp_pkg;
  // byte offsets (printed offsets are not word multiples, so index*4)
  localparam logic [7:0] value_low_index = 8'h15;
  localparam logic [7:0] value_high_index = 8'h16;
  localparam logic [7:0] mode_control_index = 8'h17;
  localparam logic [7:0] flag_index = 8'h18;
  localparam logic [7:0] timer_index = 8'h19;
  localparam logic [11:0] value_low_addr = {2'b00, value_low_index, 2'b00};
  localparam logic [11:0] value_high_addr = {2'b00, value_high_index, 2'b00};
  localparam logic [11:0] mode_control_addr = {2'b00, mode_control_index, 2'b00};
  localparam logic [11:0] flag_addr = {2'b00, flag_index, 2'b00};
  localparam logic [11:0] timer_addr = {2'b00, timer_index, 2'b00};
  // field positions
  localparam int mode_lsb = 0;
  localparam int duty_low_lsb = 4;
  localparam int event_flag_bit = 2;
  localparam logic [7:0] mode_control_reset = 8'h00;
  localparam logic [7:0] mode_control_mask = 8'h3f;
  // mode select field decode table
  localparam logic [3:0] mode_off = 4'h0;
  localparam logic [3:0] mode_cap_fall = 4'h4;
  localparam logic [3:0] mode_cap_rise = 4'h5;
  localparam logic [3:0] mode_cap_rise4 = 4'h6;
  localparam logic [3:0] mode_cap_rise16 = 4'h7;
  localparam logic [3:0] mode_cmp_set = 4'h8;
  localparam logic [3:0] mode_cmp_clear = 4'h9;
  localparam logic [3:0] mode_cmp_soft = 4'ha;
  localparam logic [3:0] mode_cmp_trig = 4'hb;
  localparam logic [3:0] mode_pwm = 4'hc;
  // capture prescale terminal counts
  localparam logic [3:0] prescale_four_last = 4'h3;
  localparam logic [3:0] prescale_sixteen_last = 4'hf;

  // pwm time-base slice handed from the main file to the pwm engine
  typedef struct packed {
    logic [7:0] period_match;
    logic [9:0] duty;
    logic active;
  } pwm_cfg_s;
endpackage : ccp_pkg

/* File: ccp_pwm_engine.sv */
// pwm engine: 10-bit time base, duty double buffer and pwm output latch
`timescale 1ns/1ns
`default_nettype none
module ccp_pwm_engine (
  input wire logic pclk, // core clock
  input wire logic presetn, // async reset, active low
  input wire logic clk_en, // freezes state while low
  input wire ccp_pkg::pwm_cfg_s cfg, // period, duty, enable
  output logic [7:0] eight_bit_timer, // timer value
  output logic [9:0] duty_buffered, // latched duty
  output logic pwm_level // pwm output latch
);
  logic [1:0] phase;
  logic wrap;
  logic [9:0] next_buf;
  logic [9:0] next_count;

  assign wrap = (phase == 2'b11) && (eight_bit_timer == cfg.period_match);
  assign next_buf = cfg.duty;
  // count of the coming cycle, so the pin is low from the cycle the count reaches duty
  assign next_count = {eight_bit_timer, phase} + 10'h001;

  // phase clock and eight-bit timer, cleared on period match
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase <= 2'b00;
      eight_bit_timer <= 8'h00;
    end else if (clk_en) begin
      if (!cfg.active) begin
        phase <= 2'b00;
        eight_bit_timer <= 8'h00;
      end else begin
        phase <= phase + 2'b01;
        if (wrap) begin
          eight_bit_timer <= 8'h00;
        end else if (phase == 2'b11) begin
          eight_bit_timer <= eight_bit_timer + 8'h01;
        end
      end
    end
  end

  // duty double buffer reloaded at rollover
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      duty_buffered <= 10'h000;
    end else if (clk_en) begin
      if (!cfg.active || wrap) begin
        duty_buffered <= next_buf;
      end
    end
  end

  // output latch: set at rollover, cleared at duty match
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwm_level <= 1'b0;
    end else if (clk_en) begin
      if (!cfg.active) begin
        pwm_level <= 1'b0;
      end else if (wrap) begin
        pwm_level <= (next_buf != 10'h000);
      end else if (duty_buffered == next_count) begin
        pwm_level <= 1'b0;
      end
    end
  end

  pwm_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && cfg.active && wrap && cfg.duty == 10'h000) |=> !pwm_level)
    else $error("pwm set with zero duty");
endmodule : ccp_pwm_engine
`default_nettype wire

/* File: ccp_unit.sv */
// capture/compare/pwm unit with apb register access
`timescale 1ns/1ns
`default_nettype none
// Behaviour
// - capture copies the sixteen-bit timer into the value bytes
// - capture event: falling, rising, every 4th or 16th rising edge
// - each capture sets event flag bit 2; software clears it
// - newer capture overwrites unread held value
// - pin driven as output still feeds the edge detector
// - prescale counter held at zero when off or not capturing
// - switching prescale settings keeps the counter
// - compare mode compares value with timer continuously
// - match drives pin high, low or unchanged and sets flag
// - writing zero to mode control forces compare latch low
// - software-interrupt compare mode only sets the flag
// - special trigger mode resets the timer on match
// - pwm mode drives the pin; software makes pin an output
// - writing zero to mode control forces pwm latch low
// - pwm period is (period match plus 1) times four phases
// - period match clears timer and sets pin unless duty zero
// - duty copied into high byte at each period rollover
// - duty is low byte plus mode control bits 5 and 4
// - pin cleared when buffered duty equals timer and phase
// - duty above the period never clears the pin
// - high value byte read-only in pwm mode
module ccp_unit (
  input wire logic pclk, // core clock, 125 MHz
  input wire logic presetn, // async reset, active low
  input wire logic clk_en, // freezes all state while low
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction
  input wire logic [11:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error on unmapped address
  input wire logic event_pin_in, // pin level as seen
  input wire logic pin_is_output, // direction bit 3 of port is clear
  input wire logic timer_tick, // sixteen-bit timer increment enable
  input wire logic [7:0] period_match_value, // eight-bit period match
  output logic event_pin_out, // output latch toward the pin
  output logic event_pin_oe, // high while the unit drives the pin
  output logic [15:0] sixteen_bit_timer, // timer value
  output logic special_trigger // one-cycle trigger pulse
);
  ////////////////////////////////////////////////////////////////////////////
  logic [7:0] capture_compare_value_low;
  logic [7:0] capture_compare_value_high;
  logic [7:0] unit_mode_control;
  logic event_flag;
  logic [3:0] prescale_count;
  logic pin_q;
  logic compare_latch;
  logic [7:0] eight_bit_timer;
  logic [9:0] duty_buffered;
  logic pwm_level;
  logic wr_acc;
  logic rd_acc;
  logic mapped;
  logic [3:0] mode;
  logic capturing;
  logic comparing;
  logic pwm_on;
  logic rise;
  logic fall;
  logic capture_now;
  logic match;
  logic flag_set;
  logic flag_clr;
  logic mode_wr;
  logic [31:0] next_prdata;
  ccp_pkg::pwm_cfg_s pwm_cfg;

  // mode decode helpers
  function automatic logic is_capture(input logic [3:0] m);
    is_capture = (m == ccp_pkg::mode_cap_fall) || (m == ccp_pkg::mode_cap_rise)
      || (m == ccp_pkg::mode_cap_rise4) || (m == ccp_pkg::mode_cap_rise16);
  endfunction : is_capture

  function automatic logic is_compare(input logic [3:0] m);
    is_compare = (m == ccp_pkg::mode_cmp_set) || (m == ccp_pkg::mode_cmp_clear)
      || (m == ccp_pkg::mode_cmp_soft) || (m == ccp_pkg::mode_cmp_trig);
  endfunction : is_compare

  ////////////////////////////////////////////////////////////////////////////
  // decode of the current mode
  assign mode = unit_mode_control[ccp_pkg::mode_lsb +: 4];
  assign capturing = is_capture(mode);
  assign comparing = is_compare(mode);
  assign pwm_on = (mode == ccp_pkg::mode_pwm);

  // apb strobes; every access completes in its first access cycle
  assign wr_acc = psel && penable && pwrite && clk_en;
  assign rd_acc = psel && penable && !pwrite && clk_en;
  assign mapped = (paddr == ccp_pkg::value_low_addr) || (paddr == ccp_pkg::value_high_addr)
    || (paddr == ccp_pkg::mode_control_addr) || (paddr == ccp_pkg::flag_addr)
    || (paddr == ccp_pkg::timer_addr);
  assign mode_wr = wr_acc && (paddr == ccp_pkg::mode_control_addr);

  // edge detection on the sampled pin, output level included
  assign rise = event_pin_in && !pin_q;
  assign fall = !event_pin_in && pin_q;

  // capture event select with prescaler
  always_comb begin
    capture_now = 1'b0;
    case (mode)
      ccp_pkg::mode_cap_fall: capture_now = fall;
      ccp_pkg::mode_cap_rise: capture_now = rise;
      ccp_pkg::mode_cap_rise4: capture_now = rise && (prescale_count[1:0] == ccp_pkg::prescale_four_last[1:0]);
      ccp_pkg::mode_cap_rise16: capture_now = rise && (prescale_count == ccp_pkg::prescale_sixteen_last);
      default: capture_now = 1'b0;
    endcase
  end

  // continuous compare of value against timer
  assign match = comparing && ({capture_compare_value_high, capture_compare_value_low}
    == sixteen_bit_timer);
  assign flag_set = capture_now || match;
  assign flag_clr = wr_acc && (paddr == ccp_pkg::flag_addr) && !pwdata[ccp_pkg::event_flag_bit];

  ////////////////////////////////////////////////////////////////////////////
  // pin sampling
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_q <= 1'b0;
    end else if (clk_en) begin
      pin_q <= event_pin_in;
    end
  end

  // prescale counter, held at zero outside capture, kept across capture modes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prescale_count <= 4'h0;
    end else if (clk_en) begin
      if (!capturing) begin
        prescale_count <= 4'h0;
      end else if (rise) begin
        prescale_count <= prescale_count + 4'h1;
      end
    end
  end

  // mode control register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      unit_mode_control <= ccp_pkg::mode_control_reset;
    end else if (clk_en && mode_wr) begin
      unit_mode_control <= pwdata[7:0] & ccp_pkg::mode_control_mask;
    end
  end

  // value low byte: software writes, capture loads
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      capture_compare_value_low <= 8'h00;
    end else if (clk_en) begin
      if (capture_now) begin
        capture_compare_value_low <= sixteen_bit_timer[7:0];
      end else if (wr_acc && paddr == ccp_pkg::value_low_addr) begin
        capture_compare_value_low <= pwdata[7:0];
      end
    end
  end

  // value high byte: capture loads, pwm buffers duty, read-only in pwm
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      capture_compare_value_high <= 8'h00;
    end else if (clk_en) begin
      if (capture_now) begin
        capture_compare_value_high <= sixteen_bit_timer[15:8];
      end else if (pwm_on) begin
        capture_compare_value_high <= duty_buffered[9:2];
      end else if (wr_acc && paddr == ccp_pkg::value_high_addr) begin
        capture_compare_value_high <= pwdata[7:0];
      end
    end
  end

  // event flag: hardware set wins over software clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      event_flag <= 1'b0;
    end else if (clk_en) begin
      if (flag_set) begin
        event_flag <= 1'b1;
      end else if (flag_clr) begin
        event_flag <= 1'b0;
      end
    end
  end

  // compare output latch
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      compare_latch <= 1'b0;
    end else if (clk_en) begin
      if (mode_wr && pwdata[7:0] == 8'h00) begin
        compare_latch <= 1'b0;
      end else if (match && mode == ccp_pkg::mode_cmp_set) begin
        compare_latch <= 1'b1;
      end else if (match && mode == ccp_pkg::mode_cmp_clear) begin
        compare_latch <= 1'b0;
      end
    end
  end

  // sixteen-bit timer with special trigger reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sixteen_bit_timer <= 16'h0000;
      special_trigger <= 1'b0;
    end else if (clk_en) begin
      special_trigger <= match && (mode == ccp_pkg::mode_cmp_trig);
      if (match && mode == ccp_pkg::mode_cmp_trig) begin
        sixteen_bit_timer <= 16'h0000;
      end else if (wr_acc && paddr == ccp_pkg::timer_addr) begin
        sixteen_bit_timer <= pwdata[15:0];
      end else if (timer_tick) begin
        sixteen_bit_timer <= sixteen_bit_timer + 16'h0001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pwm engine
  assign pwm_cfg.period_match = period_match_value;
  assign pwm_cfg.duty = {capture_compare_value_low, unit_mode_control[ccp_pkg::duty_low_lsb +: 2]};
  assign pwm_cfg.active = pwm_on;

  ccp_pwm_engine pwm_engine (
    .pclk(pclk),
    .presetn(presetn),
    .clk_en(clk_en),
    .cfg(pwm_cfg),
    .eight_bit_timer(eight_bit_timer),
    .duty_buffered(duty_buffered),
    .pwm_level(pwm_level)
  );

  // pin drive registered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      event_pin_out <= 1'b0;
      event_pin_oe <= 1'b0;
    end else if (clk_en) begin
      event_pin_out <= pwm_on ? pwm_level : compare_latch;
      event_pin_oe <= pin_is_output && (pwm_on || comparing);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // apb read mux
  always_comb begin
    next_prdata = 32'h0000_0000;
    case (paddr)
      ccp_pkg::value_low_addr: next_prdata[7:0] = capture_compare_value_low;
      ccp_pkg::value_high_addr: next_prdata[7:0] = capture_compare_value_high;
      ccp_pkg::mode_control_addr: next_prdata[7:0] = unit_mode_control;
      ccp_pkg::flag_addr: next_prdata[ccp_pkg::event_flag_bit] = event_flag;
      ccp_pkg::timer_addr: next_prdata[15:0] = sixteen_bit_timer;
      default: next_prdata = 32'h0000_0000;
    endcase
  end

  // apb answer: ready pulses on the first access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else if (clk_en) begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !mapped;
      if (psel && !penable && !pwrite) begin
        prdata <= next_prdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  capture_load_a: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && capture_now) |=> ({capture_compare_value_high, capture_compare_value_low}
      == $past(sixteen_bit_timer)))
    else $error("capture did not load timer");
  flag_sets_a: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && flag_set) |=> event_flag)
    else $error("event flag not set");
  prescale_idle_a: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && !capturing) |=> (prescale_count == 4'h0))
    else $error("prescaler not held at zero");
  rise_four_a: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && capture_now && mode == ccp_pkg::mode_cap_rise4) |-> prescale_count[1:0] == 2'b11
      ##1 prescale_count[1:0] == 2'b00)
    else $error("every fourth edge wrong");
  compare_set_a: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && match && mode == ccp_pkg::mode_cmp_set && !mode_wr) |=> compare_latch)
    else $error("compare did not drive high");
  zero_write_a: assert property (@(posedge pclk) disable iff (!presetn)
    (mode_wr && pwdata[7:0] == 8'h00) |=> !compare_latch ##1 !event_pin_out)
    else $error("zero write did not clear latch");
  trigger_reset_a: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && match && mode == ccp_pkg::mode_cmp_trig) |=> special_trigger
      && sixteen_bit_timer == 16'h0000)
    else $error("special trigger missing");
  high_readonly_a: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && pwm_on && $past(pwm_on) && $past(clk_en)) |-> capture_compare_value_high
      == $past(duty_buffered[9:2]))
    else $error("high byte not tracking duty");
  soft_only_a: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && match && mode == ccp_pkg::mode_cmp_soft && !mode_wr) |=> $stable(compare_latch))
    else $error("soft mode touched latch");

  cap_seen_c: cover property (@(posedge pclk) capture_now);
  match_seen_c: cover property (@(posedge pclk) match && mode == ccp_pkg::mode_cmp_trig);
  pwm_high_c: cover property (@(posedge pclk) pwm_on && pwm_level ##1 !pwm_level);
endmodule : ccp_unit
`default_nettype wire

/* File: ccp_pin_source.sv */
// partner model: signal source and load on the shared event pin
`timescale 1ns/1ns
`default_nettype none
module pin_source (
  input wire logic pclk, // core clock
  input wire logic oe, // unit drives the pin
  input wire logic out, // unit output latch
  output logic pin // resolved pin level
);
  logic level; // level offered by the source
  initial level = 1'b0;
  // source only drives while the unit leaves the pin alone
  assign pin = oe ? out : level;
  // whole pulses of six cycles: two high, four low
  task automatic pulses(input int n);
    repeat (n) begin
      @(posedge pclk);
      level <= 1'b1;
      repeat (2) @(posedge pclk);
      level <= 1'b0;
      repeat (3) @(posedge pclk);
    end
  endtask : pulses
endmodule : pin_source
`default_nettype wire

/* File: tb_capture_compare_pwm_unit.sv */
// testbench: apb master, pin stimulus and scenario checks for the unit
`timescale 1ns/1ns
`default_nettype none
module tb_capture_compare_pwm_unit;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er, pin;
  logic pin_is_output, timer_tick, event_pin_out, event_pin_oe, special_trigger, clk_en;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0] period_match_value;
  logic [15:0] sixteen_bit_timer;
  int n_fail, comparisons, n_trig;
  //////////////////////////////////////////////////////////////////////
  // clock, trigger pulse counter, instances
  always #4 pclk = ~pclk;
  always @(posedge pclk) if (special_trigger === 1'b1) n_trig++;
  ccp_unit dut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .event_pin_in(pin),
    .pin_is_output(pin_is_output), .timer_tick(timer_tick),
    .period_match_value(period_match_value), .event_pin_out(event_pin_out),
    .event_pin_oe(event_pin_oe), .sixteen_bit_timer(sixteen_bit_timer),
    .special_trigger(special_trigger));
  pin_source src (.pclk(pclk), .oe(event_pin_oe), .out(event_pin_out), .pin(pin));
  //////////////////////////////////////////////////////////////////////
  // compare and verdict
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic results();
    $display("counts: %0d comparisons, %0d mismatches", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : results
  // one apb transfer; read data and error kept in rd and er
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      n_fail++;
      $display("mismatch at %0t: no pready", $time);
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : bus
  task automatic wait_flag();
    int n;
    n = 0;
    do begin
      bus(1'b0, ccp_pkg::flag_addr, 0);
      n++;
    end while (rd[2] !== 1'b1 && n < 100);
  endtask : wait_flag
  //////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_regs();
    bus(1'b0, ccp_pkg::mode_control_addr, 0);
    chk(rd, 32'h0000_0000);
    bus(1'b1, ccp_pkg::mode_control_addr, 32'h0000_00f0);
    bus(1'b0, ccp_pkg::mode_control_addr, 0);
    chk(rd, 32'h0000_0030);
    bus(1'b1, ccp_pkg::mode_control_addr, 0);
    bus(1'b0, 12'h070, 0);
    chk(er, 1'b1);
    chk(rd, 32'h0000_0000);
    $display("test regs done");
  endtask : t_regs
  // if fresh, mode change with zero first, then a capture at ~t and one at a frozen timer value t
  task automatic cap_one(input logic [3:0] m, input logic [15:0] t, input logic fresh);
    if (fresh) begin
      bus(1'b1, ccp_pkg::mode_control_addr, 0);
      bus(1'b1, ccp_pkg::mode_control_addr, {28'h0, m});
    end
    bus(1'b1, ccp_pkg::timer_addr, {16'h0, ~t});
    src.pulses(1);
    bus(1'b1, ccp_pkg::flag_addr, 0);
    bus(1'b1, ccp_pkg::timer_addr, {16'h0, t});
    src.pulses(1);
    chk(sixteen_bit_timer, {16'h0, t});
    bus(1'b0, ccp_pkg::value_low_addr, 0);
    chk(rd, {24'h0, t[7:0]});
    bus(1'b0, ccp_pkg::value_high_addr, 0);
    chk(rd, {24'h0, t[15:8]});
    bus(1'b0, ccp_pkg::flag_addr, 0);
    chk(rd[2], 1'b1);
  endtask : cap_one
  task automatic t_capture();
    timer_tick <= 1'b0;
    cap_one(ccp_pkg::mode_cap_fall, 16'h5678, 1'b1);
    cap_one(ccp_pkg::mode_cap_rise, 16'h1234, 1'b1);
    cap_one(ccp_pkg::mode_cap_rise, 16'habcd, 1'b0);
    $display("test capture done");
  endtask : t_capture
  // partial count is dropped by the off write; flag only on the n-th edge
  task automatic t_prescale(input logic [3:0] m, input int n);
    bus(1'b1, ccp_pkg::mode_control_addr, {28'h0, m});
    src.pulses(n / 2);
    bus(1'b1, ccp_pkg::mode_control_addr, 0);
    bus(1'b1, ccp_pkg::mode_control_addr, {28'h0, m});
    bus(1'b1, ccp_pkg::flag_addr, 0);
    src.pulses(n - 1);
    bus(1'b0, ccp_pkg::flag_addr, 0);
    chk(rd[2], 1'b0);
    src.pulses(1);
    bus(1'b0, ccp_pkg::flag_addr, 0);
    chk(rd[2], 1'b1);
    $display("test prescale %0d done", n);
  endtask : t_prescale
  task automatic cmp_step(input logic [3:0] m, input logic e);
    bus(1'b1, ccp_pkg::mode_control_addr, {28'h0, m});
    bus(1'b1, ccp_pkg::flag_addr, 0);
    bus(1'b1, ccp_pkg::timer_addr, 0);
    wait_flag();
    chk(rd[2], 1'b1);
    repeat (2) @(posedge pclk);
    chk({event_pin_oe, event_pin_out}, {1'b1, e});
  endtask : cmp_step
  task automatic t_compare();
    pin_is_output <= 1'b1;
    timer_tick <= 1'b1;
    bus(1'b1, ccp_pkg::value_low_addr, 32'h0000_0040);
    bus(1'b1, ccp_pkg::value_high_addr, 0);
    cmp_step(ccp_pkg::mode_cmp_set, 1'b1);
    cmp_step(ccp_pkg::mode_cmp_soft, 1'b1);
    cmp_step(ccp_pkg::mode_cmp_clear, 1'b0);
    cmp_step(ccp_pkg::mode_cmp_set, 1'b1);
    bus(1'b1, ccp_pkg::mode_control_addr, 0);
    repeat (2) @(posedge pclk);
    chk(event_pin_out, 1'b0);
    n_trig = 0;
    cmp_step(ccp_pkg::mode_cmp_trig, 1'b0);
    bus(1'b0, ccp_pkg::timer_addr, 0);
    chk({rd[15:0] <= 16'h0040, n_trig > 0}, 2'b11);
    bus(1'b1, ccp_pkg::mode_control_addr, 0);
    $display("test compare done");
  endtask : t_compare
  // settle two and a half periods, then count high cycles and rising edges over four
  task automatic pwm_run(input logic [7:0] lo, input logic [1:0] fr, input int h, input int r);
    int highs, rises;
    logic prev;
    bus(1'b1, ccp_pkg::value_low_addr, {24'h0, lo});
    bus(1'b1, ccp_pkg::mode_control_addr, {26'h0, fr, ccp_pkg::mode_pwm});
    repeat (40) @(posedge pclk);
    highs = 0;
    rises = 0;
    prev = event_pin_out;
    repeat (64) begin
      @(posedge pclk);
      if (event_pin_out === 1'b1) highs++;
      if (event_pin_out === 1'b1 && prev === 1'b0) rises++;
      prev = event_pin_out;
    end
    chk(highs, h);
    chk(rises, r);
    chk(event_pin_oe, 1'b1);
  endtask : pwm_run
  task automatic t_pwm();
    pin_is_output <= 1'b1;
    period_match_value <= 8'h03;
    pwm_run(8'h01, 2'b10, 24, 4);
    bus(1'b1, ccp_pkg::value_high_addr, 32'h0000_0055);
    bus(1'b0, ccp_pkg::value_high_addr, 0);
    chk(rd, 32'h0000_0001);
    pwm_run(8'h00, 2'b00, 0, 0);
    pwm_run(8'h05, 2'b00, 64, 0);
    bus(1'b1, ccp_pkg::mode_control_addr, 0);
    repeat (2) @(posedge pclk);
    chk(event_pin_out, 1'b0);
    $display("test pwm done");
  endtask : t_pwm
  // clock enable low freezes the running timer, high lets it run on
  task automatic t_freeze();
    logic [15:0] t;
    @(posedge pclk);
    clk_en <= 1'b0;
    @(posedge pclk);
    t = sixteen_bit_timer;
    repeat (8) @(posedge pclk);
    chk(sixteen_bit_timer, t);
    clk_en <= 1'b1;
    repeat (2) @(posedge pclk);
    chk(sixteen_bit_timer != t, 1'b1);
    $display("test freeze done");
  endtask : t_freeze
  //////////////////////////////////////////////////////////////////////
  // main sequence and watchdog
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    pin_is_output = 1'b0;
    timer_tick = 1'b0;
    period_match_value = 8'h00;
    clk_en = 1'b1;
    n_fail = 0;
    comparisons = 0;
    n_trig = 0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_capture();
    t_prescale(ccp_pkg::mode_cap_rise4, 4);
    t_prescale(ccp_pkg::mode_cap_rise16, 16);
    t_compare();
    t_pwm();
    t_freeze();
    results();
  end
  initial begin
    #400_000;
    n_fail++;
    $display("mismatch at %0t: watchdog expired", $time);
    results();
  end
endmodule : tb_capture_compare_pwm_unit
`default_nettype wire
